// [ipc_port_top.sv]
// Top of the opto-isolated digital port block with pattern comparators
//
// Functional notes
// R1: Match mode raises interrupt when input word equals comparison register value.
// R2: Change mode raises interrupt when any masked input bit toggles either way.
// R3: Change mode ignores bits whose mask bit is zero.
// R4: Ports are 16 bits; one or two input and output ports.
// R5: Inputs readable and outputs writable per bit, byte or word.
// R6: Comparator and mask detection exist only on input ports.
// R7: Software selects reference width used for comparison.
// R8: Each output port selects sinking or sourcing drive polarity.
// R9: Each output port can be placed high-impedance as a whole.
// R10: Inputs synchronised, toggles found against previous cycle sample.
`timescale 1ns/100ps
`default_nettype none
module ipc_port_top
    import ipc_pkg::*;
#(
    parameter int NPORT = 2 // 1 for small variant, 2 for large
) (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [NPORT*PORT_W-1:0] fieldIn, // Field input lines
    output logic [NPORT*PORT_W-1:0] fieldOut, // Field output levels
    output logic [NPORT*PORT_W-1:0] fieldOe, // High while driving
    input wire logic [NPORT*PORT_W-1:0] rdRef, // Reference values per port
    input wire logic [NPORT*PORT_W-1:0] rdMask, // Toggle masks per port
    input wire logic [NPORT*2-1:0] cmpWidth, // Reference width per port
    input wire logic [NPORT*BIT_IDX_W-1:0] cmpBit, // Bit index for bit width
    input wire logic [NPORT*2-1:0] irqSrc, // Interrupt source per port
    input wire logic cfgWr, // Load ref, mask, width, source
    input wire logic [NPORT-1:0] irqAck, // Clears pending flag per port
    output logic [NPORT-1:0] irqPending, // Sticky event flag per port
    input wire logic [0:0] accPort, // Port selected for access
    input wire logic [1:0] accWidth, // Access width
    input wire logic [BIT_IDX_W-1:0] accIdx, // Bit index or byte index
    input wire logic accWr, // Output write strobe
    input wire logic accRd, // Input read strobe
    input wire logic [PORT_W-1:0] accWdata, // Write data, low aligned
    output logic [PORT_W-1:0] accRdata, // Read data, low aligned
    output logic accRvalid, // Read data valid pulse
    input wire logic [NPORT-1:0] srcDrive, // 1 sourcing, 0 sinking
    input wire logic [NPORT-1:0] hiZ // 1 floats the port
);
    // ------------------------------------------------------------
    // Access decode helpers
    // ------------------------------------------------------------
    // Field mask for an access of given width and index
    function automatic logic [PORT_W-1:0] accMaskOf(input logic [1:0] w,
                                                     input logic [BIT_IDX_W-1:0] idx);
        logic [PORT_W-1:0] m;
        m = IPC_ZERO_W;
        case (w)
            IPC_WIDTH_WORD: m = {PORT_W{1'b1}};
            IPC_WIDTH_BYTE: m = idx[0] ? (IPC_BYTE_MASK << BYTE_W) : IPC_BYTE_MASK;
            default: m = IPC_ONE_BIT << idx;
        endcase
        return m;
    endfunction

    // Shift amount aligning the selected field to bit zero
    function automatic logic [BIT_IDX_W-1:0] accShiftOf(input logic [1:0] w,
                                                        input logic [BIT_IDX_W-1:0] idx);
        logic [BIT_IDX_W-1:0] s;
        s = '0;
        case (w)
            IPC_WIDTH_WORD: s = '0;
            IPC_WIDTH_BYTE: s = idx[0] ? BIT_IDX_W'(BYTE_W) : '0;
            default: s = idx;
        endcase
        return s;
    endfunction

    logic [PORT_W-1:0] accMask;
    logic [BIT_IDX_W-1:0] accShift;
    logic portOk;
    assign accMask = accMaskOf(accWidth, accIdx); // R5
    assign accShift = accShiftOf(accWidth, accIdx); // R5
    assign portOk = int'(accPort) < NPORT;

    logic [NPORT*PORT_W-1:0] inSyncAll;

    // ------------------------------------------------------------
    // Per-port logic
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : gPort // R4
            ipc_chan_if chIf();
            logic [PORT_W-1:0] ref_q;
            logic [PORT_W-1:0] mask_q;
            ipc_width_t width_q;
            logic [BIT_IDX_W-1:0] bit_q;
            ipc_src_t src_q;
            logic [PORT_W-1:0] outVal_q;
            logic [PORT_W-1:0] outVal_d;
            logic selOut;
            logic [PORT_W-1:0] drvLevel;

            // Comparator config latched on cfgWr, inputs only
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ref_q <= IPC_ZERO_W;
                    mask_q <= IPC_ZERO_W;
                    width_q <= IPC_WIDTH_WORD;
                    bit_q <= '0;
                    src_q <= IPC_SRC_OFF;
                end else if (cfgWr) begin
                    ref_q <= rdRef[g*PORT_W +: PORT_W]; // R1
                    mask_q <= rdMask[g*PORT_W +: PORT_W]; // R3
                    width_q <= ipc_width_t'(cmpWidth[g*2 +: 2]); // R7
                    bit_q <= cmpBit[g*BIT_IDX_W +: BIT_IDX_W];
                    src_q <= ipc_src_t'(irqSrc[g*2 +: 2]);
                end
            end

            assign chIf.refVal = ref_q;
            assign chIf.maskVal = mask_q;
            assign chIf.width = width_q;
            assign chIf.bitSel = bit_q;
            assign chIf.source = src_q;

            // Detection sits on the input side only; output latches have none
            ipc_input_chan #(.W(PORT_W)) uChan ( // R6
                .clk(clk),
                .rst(rst),
                .pinIn(fieldIn[g*PORT_W +: PORT_W]),
                .ch(chIf.chan)
            );
            assign inSyncAll[g*PORT_W +: PORT_W] = chIf.inSync;

            // Sticky flag; a new event wins over an acknowledge
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    irqPending[g] <= 1'b0;
                end else begin
                    irqPending[g] <= chIf.irqEvent | (irqPending[g] & ~irqAck[g]); // R1 R2
                end
            end

            // Output write merges only the addressed field
            assign selOut = accWr && portOk && (int'(accPort) == g);
            assign outVal_d = selOut ?
                ((outVal_q & ~accMask) | ((accWdata << accShift) & accMask)) : outVal_q; // R5
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    outVal_q <= IPC_ZERO_W;
                end else begin
                    outVal_q <= outVal_d;
                end
            end

            // Sinking drivers invert: logic one pulls the line low
            assign drvLevel = srcDrive[g] ? outVal_q : ~outVal_q; // R8
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    fieldOut[g*PORT_W +: PORT_W] <= IPC_ZERO_W;
                    fieldOe[g*PORT_W +: PORT_W] <= IPC_ZERO_W;
                end else begin
                    fieldOut[g*PORT_W +: PORT_W] <= drvLevel; // R8
                    fieldOe[g*PORT_W +: PORT_W] <= {PORT_W{~hiZ[g]}}; // R9
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Input read path
    // ------------------------------------------------------------
    // Reads see the synchronised word, never raw pins
    logic [PORT_W-1:0] rdWord;
    logic [PORT_W-1:0] rdField;
    assign rdWord = portOk ? inSyncAll[int'(accPort)*PORT_W +: PORT_W] : IPC_ZERO_W;
    assign rdField = (rdWord & accMask) >> accShift; // R5

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            accRdata <= IPC_ZERO_W;
            accRvalid <= 1'b0;
        end else begin
            accRvalid <= accRd;
            if (accRd) begin
                accRdata <= rdField;
            end
        end
    end
endmodule
`default_nettype wire

// [ipc_pkg.sv]
// Package with constants and types for the input pattern compare port block
package ipc_pkg;
    localparam int PORT_W = 16;
    localparam int BYTE_W = 8;
    localparam int BIT_IDX_W = 4;
    // Reference width selection for the comparator
    typedef enum logic [1:0] {
        IPC_WIDTH_BIT,
        IPC_WIDTH_BYTE,
        IPC_WIDTH_WORD
    } ipc_width_t;
    // Interrupt source selection
    typedef enum logic [1:0] {
        IPC_SRC_OFF,
        IPC_SRC_EQUAL,
        IPC_SRC_TOGGLE
    } ipc_src_t;
    localparam logic [PORT_W-1:0] IPC_ZERO_W = 16'h0000;
    localparam logic [PORT_W-1:0] IPC_BYTE_MASK = 16'h00FF;
    localparam logic [PORT_W-1:0] IPC_ONE_BIT = 16'h0001;
endpackage

// [ipc_chan_if.sv]
// Interface carrying one input channel's configuration and status
`timescale 1ns/100ps
`default_nettype none
interface ipc_chan_if;
    import ipc_pkg::*;
    logic [PORT_W-1:0] inSync;
    logic [PORT_W-1:0] refVal;
    logic [PORT_W-1:0] maskVal;
    ipc_width_t width;
    logic [BIT_IDX_W-1:0] bitSel;
    ipc_src_t source;
    logic irqEvent;
    modport top (output refVal, maskVal, width, bitSel, source, input inSync, irqEvent);
    modport chan (input refVal, maskVal, width, bitSel, source, output inSync, irqEvent);
endinterface
`default_nettype wire

// [ipc_input_chan.sv]
// One 16-bit input port: synchroniser, equality and masked toggle detection
`timescale 1ns/100ps
`default_nettype none
module ipc_input_chan
    import ipc_pkg::*;
#(
    parameter int W = PORT_W
) (
    input wire logic clk, // System clock
    input wire logic rst, // Async reset, active high
    input wire logic [W-1:0] pinIn, // Raw field inputs
    ipc_chan_if.chan ch // Config and status toward top
);
    // ------------------------------------------------------------
    // Synchroniser and previous sample
    // ------------------------------------------------------------
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;
    logic armed_q;
    logic [W-1:0] togg;
    logic [W-1:0] cmpMask;
    logic equalNow;
    logic toggleNow;
    logic [W-1:0] bitOne;

    // Two stages; the logic looks only at sync_q and its delayed copy prev_q
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
            armed_q <= 1'b0;
        end else begin
            meta_q <= pinIn; // R10
            sync_q <= meta_q; // R10
            prev_q <= sync_q; // R10
            armed_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------
    // Width chooses which bits take part in the compare
    assign bitOne = W'(IPC_ONE_BIT) << ch.bitSel;
    assign cmpMask = (ch.width == IPC_WIDTH_WORD) ? {W{1'b1}} :
        (ch.width == IPC_WIDTH_BYTE) ? W'(IPC_BYTE_MASK) : bitOne; // R7
    assign equalNow = ((sync_q ^ ch.refVal) & cmpMask) == '0; // R1
    // Unmasked bits never contribute, both edges count
    assign togg = (sync_q ^ prev_q) & ch.maskVal; // R2 R3
    // armed_q masks only the first cycle after reset; the first pin sample is still compared against the reset zero in prev_q
    assign toggleNow = armed_q && (togg != '0); // R2
    assign ch.inSync = sync_q;
    assign ch.irqEvent = (ch.source == IPC_SRC_EQUAL) ? equalNow :
        (ch.source == IPC_SRC_TOGGLE) ? toggleNow : 1'b0;
endmodule
`default_nettype wire

// [ipc_port_checker.sv]
// Assertion checker for the input pattern compare port block
`timescale 1ns/100ps
`default_nettype none
module ipc_port_checker
    import ipc_pkg::*;
#(
    parameter int NPORT = 2 // Port count
) (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic [NPORT*PORT_W-1:0] fieldIn, // Inputs
    input wire logic [NPORT*PORT_W-1:0] fieldOut, // Levels
    input wire logic [NPORT*PORT_W-1:0] fieldOe, // Enables
    input wire logic [NPORT*PORT_W-1:0] rdRef, // References
    input wire logic [NPORT*PORT_W-1:0] rdMask, // Masks
    input wire logic [NPORT*2-1:0] cmpWidth, // Widths
    input wire logic [NPORT*2-1:0] irqSrc, // Sources
    input wire logic cfgWr, // Config load
    input wire logic [NPORT-1:0] irqAck, // Acks
    input wire logic [NPORT-1:0] irqPending, // Flags
    input wire logic [0:0] accPort, // Port
    input wire logic [1:0] accWidth, // Width
    input wire logic accWr, // Write
    input wire logic accRd, // Read
    input wire logic [PORT_W-1:0] accWdata, // Write data
    input wire logic [PORT_W-1:0] accRdata, // Read data
    input wire logic accRvalid, // Read valid
    input wire logic [NPORT-1:0] srcDrive, // Polarity
    input wire logic [NPORT-1:0] hiZ // Float
);
    // Port 0 shadow; age keeps the toggle-missed check AST_TOG off the first cycles after reset
    logic [15:0] m0, s0, p0, ref0, msk0;
    logic [1:0] wid0, age;
    ipc_src_t src0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {m0, s0, p0, ref0, msk0, age} <= '0;
            wid0 <= 2'h2;
            src0 <= IPC_SRC_OFF;
        end else begin
            {m0, s0, p0} <= {fieldIn[15:0], m0, s0};
            age <= age + {1'b0, age != 2'h3};
            if (cfgWr) begin
                {ref0, msk0, wid0} <= {rdRef[15:0], rdMask[15:0], cmpWidth[1:0]};
                src0 <= ipc_src_t'(irqSrc[1:0]);
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_OE: assert property (!$past(rst) |-> fieldOe[15:0] == {16{!$past(hiZ[0])}})
        else $error("enable does not follow float");
    AST_RVALID: assert property (accRvalid == $past(accRd))
        else $error("read valid misplaced");
    AST_RDATA: assert property (accRd && !accPort && accWidth == 2'h2 |=> accRdata == $past(s0))
        else $error("read word wrong");
    AST_WROUT: assert property (accWr && !accPort && accWidth == 2'h2 ##1 !accWr |=>
        fieldOut[15:0] == ($past(srcDrive[0]) ? $past(accWdata, 2) : ~$past(accWdata, 2)))
        else $error("output level wrong");
    AST_EQ: assert property (src0 == IPC_SRC_EQUAL && wid0 == 2'h2 && s0 == ref0 |=> irqPending[0])
        else $error("word match missed");
    AST_EQBYTE: assert property (src0 == IPC_SRC_EQUAL && wid0 == 2'h1 && s0[7:0] == ref0[7:0]
        |=> irqPending[0]) else $error("byte match missed");
    AST_TOG: assert property (age == 2'h3 && src0 == IPC_SRC_TOGGLE && ((s0 ^ p0) & msk0) != 16'h0
        |=> irqPending[0]) else $error("toggle missed");
    AST_NOTOG: assert property (!irqPending[0] && src0 == IPC_SRC_TOGGLE
        && ((s0 ^ p0) & msk0) == 16'h0 |=> !irqPending[0]) else $error("spurious toggle event");
    AST_OFF: assert property (src0 == IPC_SRC_OFF && (irqAck[0] || !irqPending[0])
        |=> !irqPending[0]) else $error("event while source off");
endmodule
bind ipc_port_top ipc_port_checker #(.NPORT(NPORT)) chk (.clk(clk), .rst(rst),
    .fieldIn(fieldIn), .fieldOut(fieldOut), .fieldOe(fieldOe), .rdRef(rdRef), .rdMask(rdMask),
    .cmpWidth(cmpWidth), .irqSrc(irqSrc), .cfgWr(cfgWr), .irqAck(irqAck),
    .irqPending(irqPending), .accPort(accPort), .accWidth(accWidth), .accWr(accWr),
    .accRd(accRd), .accWdata(accWdata), .accRdata(accRdata), .accRvalid(accRvalid),
    .srcDrive(srcDrive), .hiZ(hiZ));
`default_nettype wire

// [ipc_field_model.sv]
// Field-side model of the opto-isolated input lines
`timescale 1ns/100ps
`default_nettype none
module ipc_field_model (
    input wire logic clk, // System clock
    output logic [31:0] lineIn // Input lines toward the block
);
    // Changes land on a falling edge so the block never samples mid-change
    initial lineIn = 32'h0000_0000;
    task automatic drive(input logic [31:0] v);
        @(negedge clk);
        lineIn = v;
    endtask
endmodule
`default_nettype wire

// [ipc_port_top_bench.sv]
// Self-checking testbench for the input pattern compare port block
`timescale 1ns/100ps
`default_nettype none
module ipc_port_top_bench;
    import ipc_pkg::*;
    logic clk = 1'b0, rst = 1'b1, cfgWr = 1'b0, accWr = 1'b0, accRd = 1'b0, accRvalid;
    logic [0:0] accPort = 1'h0;
    logic [1:0] accWidth = 2'h0, irqAck = 2'h0, srcDrive = 2'h3, hiZ = 2'h0, irqPending;
    logic [3:0] accIdx = 4'h0, cmpWidth = 4'hA, irqSrc = 4'h0;
    logic [7:0] cmpBit = 8'h02;
    logic [15:0] accWdata = 16'h0000, accRdata;
    logic [31:0] rdRef = 32'h0, rdMask = 32'h0, fieldIn, fieldOut, fieldOe;
    int n_fail = 0;
    int checked = 0;
    ipc_port_top #(.NPORT(2)) uut (.clk(clk), .rst(rst), .fieldIn(fieldIn),
        .fieldOut(fieldOut), .fieldOe(fieldOe), .rdRef(rdRef), .rdMask(rdMask),
        .cmpWidth(cmpWidth), .cmpBit(cmpBit), .irqSrc(irqSrc), .cfgWr(cfgWr), .irqAck(irqAck),
        .irqPending(irqPending), .accPort(accPort), .accWidth(accWidth), .accIdx(accIdx),
        .accWr(accWr), .accRd(accRd), .accWdata(accWdata), .accRdata(accRdata),
        .accRvalid(accRvalid), .srcDrive(srcDrive), .hiZ(hiZ));
    ipc_field_model fm (.clk(clk), .lineIn(fieldIn));
    // 40 ns clock
    initial forever #20 clk = ~clk;
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One access; two trailing edges let read data and output level settle
    task automatic acc(input logic wr, input logic p, input logic [1:0] w,
        input logic [3:0] i, input logic [15:0] d);
        {accWr, accRd, accPort, accWidth, accIdx, accWdata} = {wr, !wr, p, w, i, d};
        step(1);
        {accWr, accRd} = 2'b00;
        step(2);
    endtask
    // Port 1 stays word wide with its source off
    task automatic cfg(input logic [15:0] r, input logic [15:0] m, input ipc_width_t w,
        input ipc_src_t s);
        {rdRef, rdMask, cmpWidth, irqSrc} = {16'h0, r, 16'h0, m, 2'h2, w, 2'h0, s};
        cfgWr = 1'b1;
        step(1);
        cfgWr = 1'b0;
    endtask
    // Port 1 comparator; port 0 word wide with its source off
    task automatic cfg1(input logic [15:0] r, input logic [15:0] m, input ipc_width_t w,
        input ipc_src_t s, input logic [3:0] b);
        {rdRef, rdMask, cmpWidth, irqSrc} = {r, 16'h0, m, 16'h0, w, 2'h2, s, 2'h0};
        cmpBit = {b, 4'h0};
        cfgWr = 1'b1;
        step(1);
        cfgWr = 1'b0;
    endtask
    // Source off first, since a live match would win over the acknowledge
    task automatic clr();
        cfg(16'h0, 16'h0, IPC_WIDTH_WORD, IPC_SRC_OFF);
        irqAck = 2'h3;
        step(1);
        irqAck = 2'h0;
        chk(irqPending, 2'h0);
    endtask
    task automatic t_io();
        fm.drive(32'h5A3C_A5C3);
        step(3);
        acc(0, 0, 2'h2, 0, 0);
        chk(accRdata, 16'hA5C3);
        acc(0, 1, 2'h1, 1, 0);
        chk(accRdata, 16'h005A);
        acc(0, 0, 2'h0, 1, 0);
        chk(accRdata, 16'h0001);
        acc(1, 0, 2'h2, 0, 16'h1234);
        chk(fieldOut[15:0], 16'h1234);
        srcDrive = 2'h1;
        acc(1, 1, 2'h1, 1, 16'h00AB);
        chk(fieldOut[31:16], 16'h54FF);
        acc(1, 0, 2'h0, 15, 16'h0001);
        chk(fieldOut[15:0], 16'h9234);
        hiZ = 2'h1;
        step(2);
        chk(fieldOe, 32'hFFFF_0000);
        chk(irqPending, 2'h0);
    endtask
    task automatic t_match();
        cfg(16'h1234, 16'h0, IPC_WIDTH_WORD, IPC_SRC_EQUAL);
        fm.drive(32'h0000_1235);
        step(3);
        chk(irqPending, 2'h0);
        fm.drive(32'h0000_1234);
        step(3);
        chk(irqPending, 2'h1);
        clr();
        cfg(16'h0034, 16'h0, IPC_WIDTH_BYTE, IPC_SRC_EQUAL);
        fm.drive(32'h0000_FF34);
        step(3);
        chk(irqPending, 2'h1);
        clr();
        cmpBit = 8'h01;
        cfg(16'h0002, 16'h0, IPC_WIDTH_BIT, IPC_SRC_EQUAL);
        step(2);
        chk(irqPending, 2'h0);
        cmpBit = 8'h02;
        cfg(16'h0004, 16'h0, IPC_WIDTH_BIT, IPC_SRC_EQUAL);
        step(1);
        chk(irqPending, 2'h1);
        clr();
    endtask
    task automatic t_tog();
        fm.drive(32'h0);
        step(3);
        cfg(16'h0, 16'h000F, IPC_WIDTH_WORD, IPC_SRC_TOGGLE);
        fm.drive(32'h0000_0100);
        step(4);
        chk(irqPending, 2'h0);
        fm.drive(32'h0000_0104);
        step(3);
        chk(irqPending, 2'h1);
        clr();
        cfg(16'h0, 16'h000F, IPC_WIDTH_WORD, IPC_SRC_TOGGLE);
        fm.drive(32'h0000_0100);
        step(3);
        chk(irqPending, 2'h1);
    endtask
    // Second port: width and source decode, unused codes included
    task automatic t_p1();
        clr();
        fm.drive(32'h01C3_0000);
        step(3);
        acc(0, 1, 2'h3, 8, 0);
        chk(accRdata, 16'h0001);
        cfg1(16'h55C3, 16'h0, IPC_WIDTH_WORD, IPC_SRC_EQUAL, 4'h0);
        step(2);
        chk(irqPending, 2'h0);
        cfg1(16'h01C3, 16'h0, IPC_WIDTH_WORD, ipc_src_t'(2'h3), 4'h0);
        step(2);
        chk(irqPending, 2'h0);
        cfg1(16'h55C3, 16'h0, IPC_WIDTH_BYTE, IPC_SRC_EQUAL, 4'h0);
        step(1);
        chk(irqPending, 2'h2);
        clr();
        cfg1(16'h0080, 16'h0, IPC_WIDTH_BIT, IPC_SRC_EQUAL, 4'h7);
        step(1);
        chk(irqPending, 2'h2);
        clr();
        cfg1(16'h0, 16'h0100, IPC_WIDTH_WORD, IPC_SRC_TOGGLE, 4'h0);
        fm.drive(32'h00C3_0000);
        step(3);
        chk(irqPending, 2'h2);
    endtask
    task automatic report_and_stop();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        step(8);
        rst = 1'b0;
        t_io();
        t_match();
        t_tog();
        t_p1();
        report_and_stop();
    end
    // Watchdog: tests need about 110 cycles, allow 5000
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end
endmodule
`default_nettype wire
